//--- core/ctr_params.svh
// Register offsets, field positions and reset values of the trip block
`ifndef CTR_PARAMS_SVH
`define CTR_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CTR_OFF_CTRL 6'h00
`define CTR_OFF_FILT 6'h04
`define CTR_OFF_STAT 6'h08
`define CTR_OFF_SCLR 6'h0C
`define CTR_OFF_RMAX 6'h10
`define CTR_OFF_RSTEP 6'h14
`define CTR_OFF_DAC 6'h18
`define CTR_OFF_ISTAT 6'h1C
`define CTR_OFF_IMASK 6'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTR_CTRL_REINIT 0
`define CTR_CTRL_TRIPWIN 1
`define CTR_FILT_THR_LSB 16
`define CTR_STAT_FILT 0
`define CTR_STAT_LATCH 1
`define CTR_STAT_RUN 2
`define CTR_IRQ_LATCH 0
`define CTR_IRQ_STOP 1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTR_RST_PRESCALE 10'h001
`define CTR_RST_THRESH 5'h01
`define CTR_RST_RMAX 16'hFFFF
`define CTR_RST_RSTEP 16'h0001

`endif

//--- core/ctr_pkg.sv
// Types shared by the trip latch and ramp block
`default_nettype none

package ctr_pkg;

    // Ramp generator state
    typedef enum logic [1:0] {
        CTR_RAMP_IDLE = 2'b01,
        CTR_RAMP_RUN = 2'b10
    } ctr_ramp_type;

endpackage : ctr_pkg

`default_nettype wire

//--- core/ctr_filter.sv
// Digitizer, sample prescaler and vote filter of the comparator output
`default_nettype none

module ctr_filter
    import ctr_pkg::*;
#(
    parameter int PRE_W = 10,
    parameter int THR_W = 5
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cmp,
    input wire logic i_reinit,
    input wire logic [PRE_W-1:0] i_prescale,
    input wire logic [THR_W-1:0] i_thresh,
    output logic o_filt_out
);

    generate
        if (PRE_W < 1 || PRE_W > 16 || THR_W < 1 || THR_W > 8) begin : g_chk
            $error("ctr_filter: unsupported width");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Sampling
    // ----------------------------------------------------------------
    logic dig_reg;
    logic [PRE_W-1:0] pre_reg;
    logic [THR_W-1:0] vote_reg;
    logic [THR_W-1:0] vote_next;
    logic filt_reg;
    logic filt_next;
    wire logic [PRE_W-1:0] pre_lim;
    wire logic [THR_W-1:0] thr_lim;
    wire logic tick;

    // Zero settings behave as one, so the filter never stalls
    assign pre_lim = (i_prescale == '0) ? PRE_W'(1) : i_prescale;
    assign thr_lim = (i_thresh == '0) ? THR_W'(1) : i_thresh;
    assign tick = (pre_reg >= pre_lim - PRE_W'(1));

    always_comb begin
        vote_next = vote_reg;
        if (tick && dig_reg && vote_reg < thr_lim) begin
            vote_next = vote_reg + THR_W'(1);
        end else if (tick && !dig_reg && vote_reg != '0) begin
            vote_next = vote_reg - THR_W'(1);
        end
        filt_next = filt_reg;
        if (vote_next >= thr_lim) begin
            filt_next = 1'b1;
        end else if (vote_next == '0) begin
            filt_next = 1'b0;
        end
    end

    // Reinit empties the sample history at once instead of waiting it out
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dig_reg <= 1'b0;
            pre_reg <= '0;
            vote_reg <= '0;
            filt_reg <= 1'b0;
        end else if (i_reinit) begin
            dig_reg <= 1'b0;
            pre_reg <= '0;
            vote_reg <= '0;
            filt_reg <= 1'b0;
        end else begin
            dig_reg <= i_cmp;
            pre_reg <= tick ? '0 : pre_reg + PRE_W'(1);
            vote_reg <= vote_next;
            filt_reg <= filt_next;
        end
    end

    assign o_filt_out = filt_reg;

endmodule : ctr_filter

`default_nettype wire

//--- core/ctr_top.sv
// Comparator trip latch, ramp generator and register slave
`default_nettype none
`include "ctr_params.svh"

module ctr_top
    import ctr_pkg::*;
#(
    parameter int DAC_W = 16,
    parameter int PRE_W = 10,
    parameter int THR_W = 5
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_cmp_high,
    input wire logic i_pwm_sync_pulse,
    input wire logic [5:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_trip_latch,
    output logic o_high_comparator_status,
    output logic [DAC_W-1:0] o_dac_value,
    output logic o_irq
);

    generate
        if (DAC_W < 4 || DAC_W > 16 || PRE_W > 16 || THR_W > 8) begin : g_chk
            $error("ctr_top: unsupported width");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Bus slave
    // ----------------------------------------------------------------
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic tripwin_reg;
    logic [PRE_W-1:0] pre_reg;
    logic [THR_W-1:0] thr_reg;
    logic [DAC_W-1:0] rmax_reg;
    logic [DAC_W-1:0] rstep_reg;
    logic [1:0] istat_reg;
    logic [1:0] istat_next;
    logic [1:0] imask_reg;
    logic [31:0] rd_mux;

    // One wait state: the first cycle of a request latches read data
    // Writes commit only at the edge that sees waitrequest low
    wire logic req = i_avs_read | i_avs_write;
    wire logic take = req & ~ack_reg;
    wire logic wr = i_avs_write & ack_reg;
    wire logic [5:0] addr = {i_avs_address[5:2], 2'b00};
    wire logic wr_ctrl = wr && addr == `CTR_OFF_CTRL;
    wire logic wr_filt = wr && addr == `CTR_OFF_FILT;
    wire logic wr_sclr = wr && addr == `CTR_OFF_SCLR;
    wire logic wr_rmax = wr && addr == `CTR_OFF_RMAX;
    wire logic wr_rstep = wr && addr == `CTR_OFF_RSTEP;
    wire logic wr_istat = wr && addr == `CTR_OFF_ISTAT;
    wire logic wr_imask = wr && addr == `CTR_OFF_IMASK;

    assign o_avs_waitrequest = req & ~ack_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (take && i_avs_read) begin
            rdata_reg <= rd_mux;
        end
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    wire logic reinit = wr_ctrl & i_avs_writedata[`CTR_CTRL_REINIT];
    wire logic sw_clear = wr_sclr & i_avs_writedata[0];

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tripwin_reg <= 1'b0;
            pre_reg <= PRE_W'(`CTR_RST_PRESCALE);
            thr_reg <= THR_W'(`CTR_RST_THRESH);
            rmax_reg <= DAC_W'(`CTR_RST_RMAX);
            rstep_reg <= DAC_W'(`CTR_RST_RSTEP);
            imask_reg <= 2'h0;
        end else begin
            if (wr_ctrl) begin
                tripwin_reg <= i_avs_writedata[`CTR_CTRL_TRIPWIN];
            end
            if (wr_filt) begin
                pre_reg <= i_avs_writedata[PRE_W-1:0];
                thr_reg <= i_avs_writedata[`CTR_FILT_THR_LSB +: THR_W];
            end
            if (wr_rmax) begin
                rmax_reg <= i_avs_writedata[DAC_W-1:0];
            end
            if (wr_rstep) begin
                rstep_reg <= i_avs_writedata[DAC_W-1:0];
            end
            if (wr_imask) begin
                imask_reg <= i_avs_writedata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Filter and trip latch
    // ----------------------------------------------------------------
    logic filt_out;
    logic latch_reg;
    logic latch_next;
    logic hs_reg;

    ctr_filter #(
        .PRE_W(PRE_W),
        .THR_W(THR_W)
    ) u_filter (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_cmp(i_cmp_high),
        .i_reinit(reinit),
        .i_prescale(pre_reg),
        .i_thresh(thr_reg),
        .o_filt_out(filt_out)
    );

    wire logic clr_any = sw_clear | i_pwm_sync_pulse;
    // Filter status rising is the trip event that stops the ramp
    wire logic hs_rise = filt_out & ~hs_reg;

    // Clear wins in its own cycle; a still-high filter re-sets next clock
    always_comb begin
        latch_next = latch_reg;
        if (clr_any) begin
            latch_next = 1'b0;
        end else if (filt_out) begin
            latch_next = 1'b1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_reg <= 1'b0;
            hs_reg <= 1'b0;
        end else begin
            latch_reg <= latch_next;
            hs_reg <= filt_out;
        end
    end

    // ----------------------------------------------------------------
    // Ramp generator
    // ----------------------------------------------------------------
    ctr_ramp_type ramp_reg;
    ctr_ramp_type ramp_next;
    logic [DAC_W-1:0] dac_reg;
    logic [DAC_W-1:0] dac_next;
    logic stop_evt;

    function automatic logic [DAC_W-1:0] sat_sub(
        input logic [DAC_W-1:0] a,
        input logic [DAC_W-1:0] b
    );
        sat_sub = (a > b) ? a - b : '0;
    endfunction : sat_sub

    // Legacy mode lets the trip beat a coincident sync, as older silicon did
    wire logic sync_ok = i_pwm_sync_pulse & ~(tripwin_reg & hs_rise);

    always_comb begin
        ramp_next = ramp_reg;
        dac_next = dac_reg;
        stop_evt = 1'b0;
        case (ramp_reg)
            CTR_RAMP_IDLE: begin
                if (sync_ok) begin
                    ramp_next = CTR_RAMP_RUN;
                    dac_next = rmax_reg;
                end
            end
            CTR_RAMP_RUN: begin
                if (sync_ok) begin
                    dac_next = rmax_reg;
                end else if (hs_rise) begin
                    ramp_next = CTR_RAMP_IDLE;
                    stop_evt = 1'b1;
                end else begin
                    dac_next = sat_sub(dac_reg, rstep_reg);
                end
            end
            default: begin
                ramp_next = CTR_RAMP_IDLE;
            end
        endcase
    end

    // Idle keeps dac_reg untouched until the next sync restarts it
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ramp_reg <= CTR_RAMP_IDLE;
            dac_reg <= '0;
        end else begin
            ramp_reg <= ramp_next;
            dac_reg <= dac_next;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    wire logic [1:0] ev = {stop_evt, latch_next & ~latch_reg};
    wire logic [1:0] w1c = wr_istat ? i_avs_writedata[1:0] : 2'h0;

    // A new event in the clearing cycle survives
    always_comb begin
        istat_next = (istat_reg & ~w1c) | ev;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            istat_reg <= 2'h0;
        end else begin
            istat_reg <= istat_next;
        end
    end

    // ----------------------------------------------------------------
    // Read mux and outputs
    // ----------------------------------------------------------------
    wire logic run = (ramp_reg == CTR_RAMP_RUN);

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (addr)
            `CTR_OFF_CTRL: rd_mux[`CTR_CTRL_TRIPWIN] = tripwin_reg;
            `CTR_OFF_FILT: begin
                rd_mux[PRE_W-1:0] = pre_reg;
                rd_mux[`CTR_FILT_THR_LSB +: THR_W] = thr_reg;
            end
            // Software reads the filter bit here before clearing the latch
            `CTR_OFF_STAT: begin
                rd_mux[`CTR_STAT_FILT] = filt_out;
                rd_mux[`CTR_STAT_LATCH] = latch_reg;
                rd_mux[`CTR_STAT_RUN] = run;
            end
            `CTR_OFF_RMAX: rd_mux[DAC_W-1:0] = rmax_reg;
            `CTR_OFF_RSTEP: rd_mux[DAC_W-1:0] = rstep_reg;
            `CTR_OFF_DAC: rd_mux[DAC_W-1:0] = dac_reg;
            `CTR_OFF_ISTAT: rd_mux[1:0] = istat_reg;
            `CTR_OFF_IMASK: rd_mux[1:0] = imask_reg;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    assign o_avs_readdata = rdata_reg;
    assign o_trip_latch = latch_reg;
    assign o_high_comparator_status = filt_out;
    assign o_dac_value = dac_reg;
    assign o_irq = |(istat_reg & imask_reg);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    // Helper: cycles the comparator has stayed high since a disturbance
    logic [31:0] hi_cnt;
    wire logic [31:0] pre_e = (pre_reg == '0) ? 32'h0000_0001 : 32'(pre_reg);
    wire logic [31:0] thr_e = (thr_reg == '0) ? 32'h0000_0001 : 32'(thr_reg);
    wire logic [31:0] lat_max = 32'h0000_0001 + pre_e + thr_e * pre_e;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            hi_cnt <= 32'h0000_0000;
        end else if (!i_cmp_high || clr_any || reinit || wr_filt || latch_reg) begin
            hi_cnt <= 32'h0000_0000;
        end else begin
            hi_cnt <= hi_cnt + 32'h0000_0001;
        end
    end

    sequence clear_seq;
        clr_any;
    endsequence

    sequence refire_seq;
        !clr_any && filt_out;
    endsequence

    latch_hold_a: assert property (latch_reg && !clr_any |=> latch_reg)
        else $error("trip latch dropped without a clear");
    latch_cause_a: assert property ($rose(latch_reg) |-> $past(filt_out))
        else $error("trip latch set without filter output");
    latch_delay_a: assert property (hi_cnt <= lat_max)
        else $error("trip latch later than the latency bound");
    clear_now_a: assert property (clear_seq |=> !latch_reg)
        else $error("trip latch not cleared at once");
    refire_next_a: assert property (clear_seq ##1 refire_seq |=> latch_reg)
        else $error("trip latch not re-set by high filter");
    filter_flush_a: assert property (reinit |=> !filt_out)
        else $error("filter not flushed by reinit");
    ramp_start_a: assert property (sync_ok |=> run && dac_reg == $past(rmax_reg))
        else $error("ramp did not restart on sync");
    ramp_fall_a: assert property (run && !i_pwm_sync_pulse && !hs_rise
        |=> dac_reg < $past(dac_reg) || dac_reg == '0 || $past(rstep_reg) == '0)
        else $error("ramp value rose while running");
    ramp_stop_a: assert property (run && hs_rise && !i_pwm_sync_pulse |=> !run)
        else $error("ramp kept running after trip");
    sync_prio_a: assert property (i_pwm_sync_pulse && hs_rise
        |=> run == !$past(tripwin_reg))
        else $error("sync and trip priority wrong");
    ramp_hold_a: assert property (!run && !i_pwm_sync_pulse |=> $stable(dac_reg))
        else $error("stopped ramp value changed");
    bus_answer_a: assert property (take |=> !o_avs_waitrequest)
        else $error("bus answer not one wait state");

    // Set side of the latch, event capture, ramp stop hold, ramp floor and write commit
    latch_set_a: assert property (filt_out && !clr_any |=> latch_reg)
        else $error("trip latch not set by filter output");
    irq_latch_a: assert property (latch_next && !latch_reg |=> istat_reg[`CTR_IRQ_LATCH])
        else $error("latch event not recorded");
    irq_stop_a: assert property (stop_evt |=> istat_reg[`CTR_IRQ_STOP])
        else $error("ramp stop event not recorded");
    stop_hold_a: assert property (stop_evt |=> !run && $stable(dac_reg))
        else $error("ramp value moved at the stop");
    ramp_floor_a: assert property (run && !i_pwm_sync_pulse && !hs_rise
        && dac_reg <= rstep_reg |=> dac_reg == '0)
        else $error("ramp did not saturate at zero");
    bus_commit_a: assert property (wr |-> !o_avs_waitrequest)
        else $error("write committed while waiting");

endmodule : ctr_top

`default_nettype wire

//--- testbench/ctr_pwm_model.sv
// Behavioural source of sync pulses standing in for the pwm_timing_module
`default_nettype none

module ctr_pwm_model (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_fire,
    input wire logic [7:0] i_period,
    output logic o_pwm_sync_pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] cnt_reg;

    // Pulses last one cycle; a zero period leaves only pulses on request
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_reg <= 8'h00;
            o_pwm_sync_pulse <= 1'b0;
        end else begin
            cnt_reg <= (cnt_reg + 8'h01 >= i_period) ? 8'h00 : cnt_reg + 8'h01;
            o_pwm_sync_pulse <= i_fire | (i_period != 8'h00 && cnt_reg == 8'h00);
        end
    end
endmodule : ctr_pwm_model

`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench of the trip latch and ramp block
`default_nettype none
`include "ctr_params.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk, rst_n, cmp, fire, rd_en, wr_en, waitreq, latch, hstat, irq, sync;
    logic [5:0] addr;
    logic [7:0] period;
    logic [31:0] wdata, rdata, q;
    logic [15:0] dac, v;
    int num_errors = 0;
    int compares = 0;

    ctr_top ctr_top_i (.i_clk(clk), .i_rst_n(rst_n), .i_cmp_high(cmp),
        .i_pwm_sync_pulse(sync), .i_avs_address(addr), .i_avs_read(rd_en),
        .i_avs_write(wr_en), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .o_trip_latch(latch),
        .o_high_comparator_status(hstat), .o_dac_value(dac), .o_irq(irq));
    ctr_pwm_model ctr_pwm_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_fire(fire),
        .i_period(period), .o_pwm_sync_pulse(sync));

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Request held until waitrequest is sampled low; an idle edge follows
    task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        r = rdata;
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask : xfer

    task automatic pulse;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask : pulse

    task automatic clean;
        cmp <= 1'b0;
        xfer(1'b1, `CTR_OFF_CTRL, 32'h0000_0001, q);
        xfer(1'b1, `CTR_OFF_SCLR, 32'h0000_0001, q);
        xfer(1'b1, `CTR_OFF_ISTAT, 32'h0000_0003, q);
    endtask : clean

    task automatic summarize;
        if (num_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        chk("latch", 32'h0, 32'(latch));
        xfer(1'b0, `CTR_OFF_FILT, 32'h0, q);
        chk("filt", 32'h0001_0001, q);
        xfer(1'b0, `CTR_OFF_RMAX, 32'h0, q);
        chk("rmax", 32'h0000_FFFF, q);
        xfer(1'b0, 6'h3C, 32'h0, q);
        chk("unmapped", 32'h0, q);
    endtask : t_reset

    task automatic t_latency(input int p, input int t);
        int n;
        n = 0;
        xfer(1'b1, `CTR_OFF_FILT, 32'(t << 16 | p), q);
        clean();
        cmp <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (latch !== 1'b1 && n < 100);
        chk("latch_delay_ok", 32'h1, 32'(n - 1 <= 1 + p + t * p));
        chk("filter_high", 32'h1, 32'(hstat));
    endtask : t_latency

    task automatic t_reset_by_sync;
        pulse();
        @(posedge clk);
        @(posedge clk);
        chk("latch_cleared", 32'h0, 32'(latch));
        @(posedge clk);
        chk("latch_set_again", 32'h1, 32'(latch));
        xfer(1'b1, `CTR_OFF_ISTAT, 32'h0000_0001, q);
        xfer(1'b0, `CTR_OFF_ISTAT, 32'h0, q);
        chk("latch_event_cleared", 32'h0, q & 32'h1);
        xfer(1'b1, `CTR_OFF_SCLR, 32'h0000_0001, q);
        xfer(1'b0, `CTR_OFF_ISTAT, 32'h0, q);
        chk("latch_event_again", 32'h1, q & 32'h1);
        @(posedge clk);
        chk("latch_sw_again", 32'h1, 32'(latch));
    endtask : t_reset_by_sync

    task automatic t_hold;
        cmp <= 1'b0;
        repeat (20) @(posedge clk);
        xfer(1'b0, `CTR_OFF_STAT, 32'h0, q);
        chk("filter_low_latch_on", 32'h2, q & 32'h3);
        xfer(1'b1, `CTR_OFF_SCLR, 32'h0000_0001, q);
        repeat (10) @(posedge clk);
        chk("latch_stays_clear", 32'h0, 32'(latch));
    endtask : t_hold

    task automatic t_glitch;
        xfer(1'b1, `CTR_OFF_FILT, 32'h0002_0001, q);
        clean();
        cmp <= 1'b1;
        @(posedge clk);
        cmp <= 1'b0;
        repeat (10) @(posedge clk);
        chk("glitch_latch", 32'h0, 32'(latch));
    endtask : t_glitch

    task automatic t_reinit;
        int n;
        n = 0;
        xfer(1'b1, `CTR_OFF_FILT, 32'h0003_0064, q);
        clean();
        cmp <= 1'b1;
        while (hstat !== 1'b1 && n < 600) begin
            @(posedge clk);
            n++;
        end
        cmp <= 1'b0;
        xfer(1'b0, `CTR_OFF_STAT, 32'h0, q);
        chk("filter_slow", 32'h1, q & 32'h1);
        xfer(1'b1, `CTR_OFF_CTRL, 32'h0000_0001, q);
        @(posedge clk);
        chk("filter_flushed", 32'h0, 32'(hstat));
        xfer(1'b1, `CTR_OFF_FILT, 32'h0001_0001, q);
        clean();
    endtask : t_reinit

    task automatic t_ramp;
        int n;
        n = 0;
        xfer(1'b1, `CTR_OFF_RSTEP, 32'h0000_0003, q);
        xfer(1'b1, `CTR_OFF_RMAX, 32'h0000_0100, q);
        xfer(1'b1, `CTR_OFF_IMASK, 32'h0000_0002, q);
        pulse();
        @(posedge clk);
        @(posedge clk);
        chk("dac_reload", 32'h0000_0100, 32'(dac));
        @(posedge clk);
        chk("dac_step", 32'h0000_00FD, 32'(dac));
        cmp <= 1'b1;
        repeat (5) @(posedge clk);
        v = dac;
        repeat (10) @(posedge clk);
        chk("dac_held", 32'(v), 32'(dac));
        xfer(1'b0, `CTR_OFF_STAT, 32'h0, q);
        chk("ramp_stopped", 32'h0, q & 32'h4);
        chk("irq_raised", 32'h1, 32'(irq));
        xfer(1'b1, `CTR_OFF_IMASK, 32'h0, q);
        chk("irq_masked", 32'h0, 32'(irq));
        xfer(1'b1, `CTR_OFF_IMASK, 32'h0000_0002, q);
        chk("irq_unmasked", 32'h1, 32'(irq));
        xfer(1'b1, `CTR_OFF_ISTAT, 32'h0000_0002, q);
        chk("irq_cleared", 32'h0, 32'(irq));
        cmp <= 1'b0;
        repeat (6) @(posedge clk);
        period <= 8'h28;
        while (dac !== 16'h0100 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("dac_restart", 32'h0000_0100, 32'(dac));
        period <= 8'h00;
    endtask : t_ramp

    task automatic t_coincide(input logic win);
        clean();
        xfer(1'b1, `CTR_OFF_CTRL, 32'({win, 1'b0}), q);
        pulse();
        repeat (3) @(posedge clk);
        cmp <= 1'b1;
        @(posedge clk);
        pulse();
        @(posedge clk);
        xfer(1'b0, `CTR_OFF_STAT, 32'h0, q);
        chk("run_after_tie", 32'({!win, 2'b00}), q & 32'h4);
    endtask : t_coincide

    // ----------------------------------------------------------------
    // Run
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        cmp = 1'b0;
        fire = 1'b0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        addr = 6'h00;
        wdata = 32'h0;
        period = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_latency(1, 1);
        t_latency(2, 3);
        t_reset_by_sync();
        t_hold();
        t_glitch();
        t_reinit();
        t_ramp();
        t_coincide(1'b1);
        t_coincide(1'b0);
        summarize();
    end
endmodule : tb_top

`default_nettype wire
